// >>> pfs_defines.svh
// constants for the program flow sequencer
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH
`define PFS_PC_W        8
`define PFS_STACK_DEPTH 8
`define PFS_SP_W        4
`define PFS_ADDR_W      4
`define PFS_CNT_W       16
`define PFS_SLOTS       16
`define PFS_SLOT_W      4
`define PFS_CLK_HZ      40000000
// wait granularity: one tick per millisecond of delay argument
`define PFS_TICK_MS     1
`define PFS_TICK_CYC    ((`PFS_CLK_HZ / 1000) * `PFS_TICK_MS)
// register byte offsets
`define PFS_REG_CTRL    8'h00
`define PFS_REG_STATUS  8'h04
`define PFS_REG_PC      8'h08
`define PFS_REG_SP      8'h0c
`define PFS_REG_IO      8'h10
`define PFS_REG_PEND    8'h14
// control register bits
`define PFS_CTRL_RUN    0
`define PFS_CTRL_CLRP   1
`endif

// >>> pfs_pkg.sv
// types of the program flow sequencer
package pfs_pkg;
    typedef enum logic [2:0] {
        PFS_OP_NEXT,
        PFS_OP_GOTO,
        PFS_OP_GOTO_IF,
        PFS_OP_JUMP_N,
        PFS_OP_CALL,
        PFS_OP_RETURN,
        PFS_OP_RETURN_AND_REDIRECT,
        PFS_OP_WAIT
    } pfs_op_t;
    typedef enum logic [1:0] {
        PFS_TEST_NONE,
        PFS_TEST_HIGH,
        PFS_TEST_LOW
    } pfs_test_t;
    typedef enum {
        PFS_ST_IDLE,
        PFS_ST_FETCH,
        PFS_ST_EXEC,
        PFS_ST_WAIT
    } pfs_state_t;
endpackage

// >>> pfs_stack.sv
// return stack memory with registered read data
`timescale 1ns/1ps
`include "pfs_defines.svh"
module pfs_stack (
    input  wire logic                    i_clk,
    input  wire logic                    i_we,
    input  wire logic [`PFS_SP_W-2:0]    i_waddr,
    input  wire logic [`PFS_PC_W-1:0]    i_wdata,
    input  wire logic [`PFS_SP_W-2:0]    i_raddr,
    output      logic [`PFS_PC_W-1:0]    o_rdata
);
    logic [`PFS_PC_W-1:0] mem [0:`PFS_STACK_DEPTH-1];
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule

// >>> pfs_jumpcnt.sv
// remaining-count table for counted jumps, one slot per command
`timescale 1ns/1ps
`include "pfs_defines.svh"
module pfs_jumpcnt (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst,
    input  wire logic                    i_clr_all,
    input  wire logic                    i_we,
    input  wire logic [`PFS_SLOT_W-1:0]  i_slot,
    input  wire logic [`PFS_CNT_W-1:0]   i_wdata,
    input  wire logic                    i_wact,
    output      logic [`PFS_CNT_W-1:0]   o_rdata,
    output      logic                    o_ract
);
    // active flags clear in one cycle; counts are reloaded on first use
    logic [`PFS_SLOTS-1:0] act;
    logic [`PFS_CNT_W-1:0] cnt [0:`PFS_SLOTS-1];
    always_ff @(posedge i_clk) begin
        if (i_rst || i_clr_all) begin
            act <= '0;
        end else if (i_we) begin
            act[i_slot] <= i_wact;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            cnt[i_slot] <= i_wdata;
        end
    end
    assign o_rdata = cnt[i_slot];
    assign o_ract  = act[i_slot];
endmodule

// >>> pfs_core.sv
// program flow sequencer: branching, calls, returns and timed wait
//
// What this block does
// - each conditional line carries high, low or ignore per input and output
// - condition sampled at execution; jump only when every tested line matches
// - any tested mismatch advances to the following program line
// - subroutine call loads the resolved destination line
// - plain return resumes at the line after the call
// - return-and-redirect empties the whole return stack
// - return-and-redirect drops pending interrupts and resets jump counts
// - return-and-redirect then continues at its destination line
// - timed wait holds the next command until the delay elapses
// - counted jump branches the set number of times, then falls through
// - unconditional branch always loads the destination line
`timescale 1ns/1ps
`include "pfs_defines.svh"
module pfs_core
    import pfs_pkg::*;
(
    // clock and reset
    input  wire logic                   I_CLK,
    input  wire logic                   I_SYS_RST,
    // axi4-lite write address and data
    input  wire logic [`PFS_ADDR_W+3:0] I_AWADDR,
    input  wire logic                   I_AWVALID,
    output      logic                   O_AWREADY,
    input  wire logic [31:0]            I_WDATA,
    input  wire logic [3:0]             I_WSTRB,
    input  wire logic                   I_WVALID,
    output      logic                   O_WREADY,
    // axi4-lite write response
    output      logic [1:0]             O_BRESP,
    output      logic                   O_BVALID,
    input  wire logic                   I_BREADY,
    // axi4-lite read
    input  wire logic [`PFS_ADDR_W+3:0] I_ARADDR,
    input  wire logic                   I_ARVALID,
    output      logic                   O_ARREADY,
    output      logic [31:0]            O_RDATA,
    output      logic [1:0]             O_RRESP,
    output      logic                   O_RVALID,
    input  wire logic                   I_RREADY,
    // program line fetch (same clock domain, one cycle latency)
    output      logic [`PFS_PC_W-1:0]   O_FETCH_ADDR,
    output      logic                   O_FETCH_REQ,
    input  wire logic [2:0]             I_LINE_OP,
    input  wire logic [`PFS_PC_W-1:0]   I_LINE_DEST,
    input  wire logic [15:0]            I_LINE_COND,
    input  wire logic [`PFS_CNT_W-1:0]  I_LINE_ARG,
    input  wire logic [`PFS_SLOT_W-1:0] I_LINE_SLOT,
    // general purpose io
    input  wire logic [3:0]             I_GP_IN,
    input  wire logic [3:0]             I_GP_OUT,
    // pending interrupt set from the interrupt sources
    input  wire logic [3:0]             I_PEND_SET,
    // other commands executed outside this block
    output      logic                   O_EXT_CMD,
    input  wire logic                   I_EXT_DONE,
    output      logic [3:0]             O_PEND,
    output      logic                   O_JUMP_CLR,
    output      logic                   O_RUNNING
);
    // condition test: two bits per line, inputs in low byte
    function automatic logic cond_ok(input logic [15:0] c,
                                     input logic [7:0] lv);
        logic ok;
        ok = 1'b1;
        for (int k = 0; k < 8; k++) begin
            if (pfs_test_t'(c[2*k +: 2]) == PFS_TEST_HIGH && !lv[k]) begin
                ok = 1'b0;
            end
            if (pfs_test_t'(c[2*k +: 2]) == PFS_TEST_LOW && lv[k]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    pfs_state_t            state;
    pfs_state_t            next_state;
    logic [`PFS_PC_W-1:0]  pc;
    logic [`PFS_PC_W-1:0]  next_pc;
    logic [`PFS_SP_W-1:0]  sp;
    logic [`PFS_SP_W-1:0]  next_sp;
    logic [3:0]            in_s1;
    logic [3:0]            in_s2;
    logic [3:0]            out_s1;
    logic [3:0]            out_s2;
    logic [3:0]            pend;
    logic                  run;
    logic                  overflow;
    logic                  underflow;
    logic [`PFS_CNT_W-1:0] wait_ticks;
    logic [31:0]           wait_cyc;
    logic                  ret_wait;
    logic [`PFS_PC_W-1:0]  stk_rdata;
    logic [`PFS_CNT_W-1:0] jc_rdata;
    logic                  jc_ract;

    // io pins cross into this domain through two flops
    always_ff @(posedge I_CLK) begin
        in_s1  <= I_GP_IN;
        in_s2  <= in_s1;
        out_s1 <= I_GP_OUT;
        out_s2 <= out_s1;
    end

    pfs_op_t op;
    wire cond_met  = cond_ok(I_LINE_COND, {out_s2, in_s2});
    wire [`PFS_PC_W-1:0] pc_inc = pc + `PFS_PC_W'(1);
    wire exec      = (state == PFS_ST_EXEC);
    wire is_call   = exec && op == PFS_OP_CALL;
    wire is_ret    = exec && op == PFS_OP_RETURN;
    wire is_rr     = exec && op == PFS_OP_RETURN_AND_REDIRECT;
    wire is_jn     = exec && op == PFS_OP_JUMP_N;
    wire stk_full  = (sp == `PFS_SP_W'(`PFS_STACK_DEPTH));
    wire stk_empty = (sp == '0);
    wire push      = is_call && !stk_full;
    wire jn_take   = jc_ract ? (jc_rdata != '0) : (I_LINE_ARG != '0);
    wire [`PFS_CNT_W-1:0] jn_left = jc_ract ? jc_rdata : I_LINE_ARG;
    wire tick_done = (wait_cyc == 32'(`PFS_TICK_CYC - 1));
    assign op = pfs_op_t'(I_LINE_OP);

    // next program counter and stack pointer for each command
    always_comb begin
        next_pc    = pc;
        next_sp    = sp;
        next_state = state;
        case (state)
            PFS_ST_IDLE: begin
                // a stack fault holds the program until run is cleared
                if (run && !overflow && !underflow) begin
                    next_state = PFS_ST_FETCH;
                end
            end
            PFS_ST_FETCH: begin
                next_state = run ? PFS_ST_EXEC : PFS_ST_IDLE;
            end
            PFS_ST_EXEC: begin
                next_state = PFS_ST_FETCH;
                next_pc    = pc_inc;
                case (op)
                    PFS_OP_GOTO: next_pc = I_LINE_DEST;
                    PFS_OP_GOTO_IF: begin
                        if (cond_met) begin
                            next_pc = I_LINE_DEST;
                        end else begin
                            next_pc = pc_inc;
                        end
                    end
                    PFS_OP_JUMP_N: begin
                        if (jn_take) begin
                            next_pc = I_LINE_DEST;
                        end
                    end
                    PFS_OP_CALL: begin
                        if (!stk_full) begin
                            next_pc = I_LINE_DEST;
                            next_sp = sp + `PFS_SP_W'(1);
                        end else begin
                            next_state = PFS_ST_IDLE;
                        end
                    end
                    PFS_OP_RETURN: begin
                        if (!stk_empty) begin
                            next_sp    = sp - `PFS_SP_W'(1);
                            next_state = PFS_ST_WAIT;
                        end else begin
                            next_state = PFS_ST_IDLE;
                        end
                    end
                    PFS_OP_RETURN_AND_REDIRECT: begin
                        next_sp = '0;
                        next_pc = I_LINE_DEST;
                    end
                    PFS_OP_WAIT: begin
                        if (I_LINE_ARG != '0) begin
                            next_state = PFS_ST_WAIT;
                        end
                    end
                    PFS_OP_NEXT: begin
                        if (!I_EXT_DONE) begin
                            next_pc    = pc;
                            next_state = PFS_ST_EXEC;
                        end
                    end
                    default: next_pc = pc_inc;
                endcase
            end
            PFS_ST_WAIT: begin
                if (ret_wait) begin
                    next_pc    = stk_rdata;
                    next_state = PFS_ST_FETCH;
                end else if (tick_done && wait_ticks == `PFS_CNT_W'(1)) begin
                    next_state = PFS_ST_FETCH;
                end
            end
            default: next_state = PFS_ST_IDLE;
        endcase
        if (!run) begin
            next_state = PFS_ST_IDLE;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            state <= PFS_ST_IDLE;
            pc    <= '0;
            sp    <= '0;
        end else begin
            state <= next_state;
            pc    <= next_pc;
            sp    <= next_sp;
        end
    end

    // wait timer: ticks of one millisecond
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            wait_ticks <= '0;
            wait_cyc   <= '0;
            ret_wait   <= 1'b0;
        end else if (exec) begin
            wait_ticks <= I_LINE_ARG;
            wait_cyc   <= '0;
            ret_wait   <= is_ret;
        end else if (state == PFS_ST_WAIT && !ret_wait) begin
            wait_cyc <= tick_done ? '0 : wait_cyc + 32'd1;
            if (tick_done) begin
                wait_ticks <= wait_ticks - `PFS_CNT_W'(1);
            end
        end
    end

    // stack read address targets the current top entry
    wire [`PFS_SP_W-1:0] sp_dec    = sp - `PFS_SP_W'(1);
    wire [`PFS_SP_W-2:0] stk_raddr = sp_dec[`PFS_SP_W-2:0];
    pfs_stack u_stack (
        .i_clk   (I_CLK),
        .i_we    (push),
        .i_waddr (sp[`PFS_SP_W-2:0]),
        .i_wdata (pc_inc),
        .i_raddr (stk_raddr),
        .o_rdata (stk_rdata)
    );

    wire jc_clr = I_SYS_RST || is_rr;
    pfs_jumpcnt u_jumpcnt (
        .i_clk     (I_CLK),
        .i_rst     (I_SYS_RST),
        .i_clr_all (is_rr),
        .i_we      (is_jn),
        .i_slot    (I_LINE_SLOT),
        .i_wdata   (jn_take ? jn_left - `PFS_CNT_W'(1) : jn_left),
        .i_wact    (jn_take),
        .o_rdata   (jc_rdata),
        .o_ract    (jc_ract)
    );

    // register bus: write path accepts address and data in any order
    logic                   aw_held;
    logic                   w_held;
    logic [`PFS_ADDR_W+3:0] aw_addr;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    wire aw_go = I_AWVALID && O_AWREADY;
    wire w_go  = I_WVALID && O_WREADY;
    wire wr_do = aw_held && w_held && !O_BVALID;
    wire ctrl_hit = (aw_addr == `PFS_REG_CTRL);
    wire clr_pend = wr_do && ctrl_hit && w_strb[0] &&
                    w_data[`PFS_CTRL_CLRP];
    wire drop_pend = is_rr || clr_pend;

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr   <= '0;
            w_data    <= '0;
            w_strb    <= '0;
            O_AWREADY <= 1'b0;
            O_WREADY  <= 1'b0;
            O_BVALID  <= 1'b0;
            O_BRESP   <= 2'h0;
            run       <= 1'b0;
        end else begin
            O_AWREADY <= !aw_held && !aw_go && !O_AWREADY;
            O_WREADY  <= !w_held && !w_go && !O_WREADY;
            if (aw_go) begin
                aw_held <= 1'b1;
                aw_addr <= I_AWADDR;
            end
            if (w_go) begin
                w_held <= 1'b1;
                w_data <= I_WDATA;
                w_strb <= I_WSTRB;
            end
            if (wr_do) begin
                aw_held  <= 1'b0;
                w_held   <= 1'b0;
                O_BVALID <= 1'b1;
                O_BRESP  <= ctrl_hit ? 2'h0 : 2'h2;
                if (ctrl_hit && w_strb[0]) begin
                    run <= w_data[`PFS_CTRL_RUN];
                end
            end else if (O_BVALID && I_BREADY) begin
                O_BVALID <= 1'b0;
            end
        end
    end

    // pending set: a new request wins over a clear in the same cycle
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            pend <= '0;
        end else begin
            pend <= (drop_pend ? 4'h0 : pend) | I_PEND_SET;
        end
    end

    // read path
    wire [`PFS_ADDR_W+3:0] ra = I_ARADDR;
    wire [31:0] rd_mux =
        (ra == `PFS_REG_CTRL)   ? {31'h0, run} :
        (ra == `PFS_REG_STATUS) ? {28'h0, overflow, underflow,
                                   state == PFS_ST_WAIT, O_RUNNING} :
        (ra == `PFS_REG_PC)     ? {24'h0, pc} :
        (ra == `PFS_REG_SP)     ? {28'h0, sp} :
        (ra == `PFS_REG_IO)     ? {24'h0, out_s2, in_s2} :
        (ra == `PFS_REG_PEND)   ? {28'h0, pend} : 32'h0;
    wire rd_hit = (ra == `PFS_REG_CTRL) || (ra == `PFS_REG_STATUS) ||
                  (ra == `PFS_REG_PC) || (ra == `PFS_REG_SP) ||
                  (ra == `PFS_REG_IO) || (ra == `PFS_REG_PEND);

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            O_ARREADY <= 1'b0;
            O_RVALID  <= 1'b0;
            O_RDATA   <= '0;
            O_RRESP   <= 2'h0;
        end else begin
            O_ARREADY <= I_ARVALID && !O_ARREADY && !O_RVALID;
            if (I_ARVALID && O_ARREADY) begin
                O_RVALID <= 1'b1;
                O_RDATA  <= rd_mux;
                O_RRESP  <= rd_hit ? 2'h0 : 2'h2;
            end else if (O_RVALID && I_RREADY) begin
                O_RVALID <= 1'b0;
            end
        end
    end

    // sticky stack faults, cleared by stopping the program
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            overflow     <= 1'b0;
            underflow    <= 1'b0;
            O_FETCH_ADDR <= '0;
            O_FETCH_REQ  <= 1'b0;
            O_EXT_CMD    <= 1'b0;
            O_PEND       <= '0;
            O_JUMP_CLR   <= 1'b0;
            O_RUNNING    <= 1'b0;
        end else begin
            overflow  <= (overflow && run) || (is_call && stk_full);
            underflow <= (underflow && run) || (is_ret && stk_empty);
            O_FETCH_ADDR <= next_pc;
            O_FETCH_REQ  <= (next_state == PFS_ST_FETCH);
            O_EXT_CMD    <= exec && op == PFS_OP_NEXT && I_EXT_DONE;
            O_PEND       <= (drop_pend ? 4'h0 : pend) | I_PEND_SET;
            O_JUMP_CLR   <= jc_clr;
            O_RUNNING    <= (next_state != PFS_ST_IDLE);
        end
    end
endmodule

// >>> pfs_core_assertions.sv
// concurrent checks on the sequencer top ports
`timescale 1ns/1ps
module pfs_core_chk (
    input  wire logic        I_CLK,
    input  wire logic        I_SYS_RST,
    input  wire logic        I_AWVALID,
    input  wire logic        O_AWREADY,
    input  wire logic        I_WVALID,
    input  wire logic        O_WREADY,
    input  wire logic        O_BVALID,
    input  wire logic        I_ARVALID,
    input  wire logic        O_ARREADY,
    input  wire logic        O_RVALID,
    input  wire logic [2:0]  I_LINE_OP,
    input  wire logic [3:0]  I_PEND_SET,
    input  wire logic        O_EXT_CMD,
    input  wire logic [3:0]  O_PEND,
    input  wire logic        O_JUMP_CLR
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    sequence s_wr_taken;
        I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
    endsequence
    sequence s_wr_answer;
        ##[1:4] O_BVALID;
    endsequence
    sequence s_redirect;
        $rose(O_JUMP_CLR);
    endsequence
    chk_wr_answer: assert property (s_wr_taken |-> s_wr_answer)
        else $error("write response late");
    chk_rd_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
        else $error("read data not the cycle after address");
    chk_awready_pulse: assert property (O_AWREADY |=> !O_AWREADY)
        else $error("write address ready held");
    chk_arready_pulse: assert property (O_ARREADY |=> !O_ARREADY)
        else $error("read address ready held");
    chk_ext_pulse: assert property (O_EXT_CMD |=> !O_EXT_CMD)
        else $error("external command strobe held");
    chk_pend_set: assert property (I_PEND_SET != 4'h0 |=>
        (O_PEND & $past(I_PEND_SET)) == $past(I_PEND_SET))
        else $error("pending bit not set");
    chk_pend_cause: assert property (
        ((O_PEND & ~$past(O_PEND)) & ~$past(I_PEND_SET)) == 4'h0)
        else $error("pending bit rose without a source");
    chk_jclr_cause: assert property (
        s_redirect |-> $past(I_LINE_OP) == 3'h6 &&
        O_PEND == $past(I_PEND_SET))
        else $error("jump clear without redirect");
    chk_jclr_single: assert property (s_redirect |=> !O_JUMP_CLR)
        else $error("jump clear longer than one cycle");
endmodule

bind pfs_core pfs_core_chk pfs_core_chk_inst (
    .I_CLK, .I_SYS_RST, .I_AWVALID, .O_AWREADY, .I_WVALID, .O_WREADY,
    .O_BVALID, .I_ARVALID, .O_ARREADY, .O_RVALID, .I_LINE_OP,
    .I_PEND_SET, .O_EXT_CMD, .O_PEND, .O_JUMP_CLR
);

// >>> pfs_prog_model.sv
// stored program memory answering line fetches one cycle later
`timescale 1ns/1ps
module pfs_prog_model (
    // fetch request
    input  wire logic        i_clk,
    input  wire logic        i_fetch_req,
    input  wire logic [7:0]  i_fetch_addr,
    // line fields, held until the next fetch
    output      logic [2:0]  o_op,
    output      logic [7:0]  o_dest,
    output      logic [15:0] o_cond,
    output      logic [15:0] o_arg,
    output      logic [3:0]  o_slot
);
    // fields: op, resolved destination, condition, argument, slot
    function automatic logic [46:0] line(input logic [7:0] a);
        case (a)
            8'h00:   line = {3'h2, 8'h03, 16'h0001, 16'h0000, 4'h0};
            8'h01:   line = {3'h2, 8'h03, 16'h4002, 16'h0000, 4'h0};
            8'h04:   line = {3'h3, 8'h03, 16'h0000, 16'h0002, 4'h0};
            8'h05:   line = {3'h4, 8'h09, 16'h0000, 16'h0000, 4'h0};
            8'h06:   line = {3'h7, 8'h00, 16'h0000, 16'h0001, 4'h0};
            8'h07:   line = {3'h4, 8'h0b, 16'h0000, 16'h0000, 4'h0};
            8'h09:   line = {3'h5, 8'h00, 16'h0000, 16'h0000, 4'h0};
            8'h0b:   line = {3'h4, 8'h0c, 16'h0000, 16'h0000, 4'h0};
            8'h0c:   line = {3'h6, 8'h0e, 16'h0000, 16'h0000, 4'h0};
            8'h0e:   line = {3'h5, 8'h00, 16'h0000, 16'h0000, 4'h0};
            default: line = {3'h0, 8'h00, 16'h0000, 16'h0000, 4'h0};
        endcase
    endfunction
    initial begin
        {o_op, o_dest, o_cond, o_arg, o_slot} = '0;
    end
    // fields must stay put while the line executes, so latch per fetch
    always @(posedge i_clk) begin
        if (i_fetch_req) begin
            {o_op, o_dest, o_cond, o_arg, o_slot} <= line(i_fetch_addr);
        end
    end
endmodule

// >>> test_program_flow_sequencer.sv
// self-checking bench for the program flow sequencer
`timescale 1ns/1ps
module test_program_flow_sequencer;
    import pfs_pkg::*;
    logic        I_CLK, I_SYS_RST, I_AWVALID, I_WVALID, I_BREADY;
    logic        I_ARVALID, I_RREADY, I_EXT_DONE;
    logic [7:0]  I_AWADDR, I_ARADDR, I_LINE_DEST;
    logic [31:0] I_WDATA;
    logic [3:0]  I_WSTRB, I_GP_IN, I_GP_OUT, I_PEND_SET, I_LINE_SLOT;
    logic [2:0]  I_LINE_OP;
    logic [15:0] I_LINE_COND, I_LINE_ARG;
    logic        O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
    logic        O_FETCH_REQ, O_EXT_CMD, O_JUMP_CLR, O_RUNNING;
    logic [1:0]  O_BRESP, O_RRESP;
    logic [31:0] O_RDATA;
    logic [7:0]  O_FETCH_ADDR;
    logic [3:0]  O_PEND;
    int          n_mismatch, n_checks, cyc, n_ext, n_jclr;
    logic [7:0]  fa[$];
    int          ft[$];
    logic [1:0]  r;
    logic [31:0] d;
    pfs_core pfs_core_inst (.I_CLK, .I_SYS_RST, .I_AWADDR, .I_AWVALID,
        .O_AWREADY, .I_WDATA, .I_WSTRB, .I_WVALID, .O_WREADY, .O_BRESP,
        .O_BVALID, .I_BREADY, .I_ARADDR, .I_ARVALID, .O_ARREADY, .O_RDATA,
        .O_RRESP, .O_RVALID, .I_RREADY, .O_FETCH_ADDR, .O_FETCH_REQ,
        .I_LINE_OP, .I_LINE_DEST, .I_LINE_COND, .I_LINE_ARG, .I_LINE_SLOT,
        .I_GP_IN, .I_GP_OUT, .I_PEND_SET, .O_EXT_CMD, .I_EXT_DONE, .O_PEND,
        .O_JUMP_CLR, .O_RUNNING);
    pfs_prog_model pfs_prog_model_inst (.i_clk(I_CLK),
        .i_fetch_req(O_FETCH_REQ), .i_fetch_addr(O_FETCH_ADDR),
        .o_op(I_LINE_OP), .o_dest(I_LINE_DEST), .o_cond(I_LINE_COND),
        .o_arg(I_LINE_ARG), .o_slot(I_LINE_SLOT));
    initial begin
        I_CLK = 1'b0;
        forever #12.5 I_CLK = ~I_CLK;
    end
    // fetch log with cycle stamps, strobe counts after reset
    always @(posedge I_CLK) begin
        cyc <= cyc + 1;
        if (O_FETCH_REQ === 1'b1) begin
            fa.push_back(O_FETCH_ADDR);
            ft.push_back(cyc);
        end
        if (O_EXT_CMD === 1'b1) n_ext <= n_ext + 1;
        if (O_JUMP_CLR === 1'b1 && I_SYS_RST === 1'b0) n_jclr <= n_jclr + 1;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v,
                          output logic [1:0] resp);
        int n;
        @(posedge I_CLK);
        I_AWADDR  <= a;
        I_WDATA   <= v;
        I_AWVALID <= 1'b1;
        I_WVALID  <= 1'b1;
        I_BREADY  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge I_CLK);
            if (I_AWVALID && O_AWREADY) I_AWVALID <= 1'b0;
            if (I_WVALID && O_WREADY) I_WVALID <= 1'b0;
            if (O_BVALID === 1'b1) break;
        end
        resp = O_BRESP;
        I_BREADY <= 1'b0;
    endtask
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] v,
                          output logic [1:0] resp);
        int n;
        @(posedge I_CLK);
        I_ARADDR  <= a;
        I_ARVALID <= 1'b1;
        I_RREADY  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge I_CLK);
            if (I_ARVALID && O_ARREADY) I_ARVALID <= 1'b0;
            if (O_RVALID === 1'b1) break;
        end
        v = O_RDATA;
        resp = O_RRESP;
        I_RREADY <= 1'b0;
    endtask
    task automatic test_refuse;
        bus_wr(8'h04, 32'h0000_0001, r);
        check(r, 32'h2);
        bus_rd(8'h3c, d, r);
        check(r, 32'h2);
        check(d, 32'h0);
        $display("test_refuse done");
    endtask
    task automatic test_levels;
        @(posedge I_CLK);
        I_PEND_SET <= 4'h5;
        @(posedge I_CLK);
        I_PEND_SET <= 4'h0;
        bus_rd(8'h10, d, r);
        check(d, 32'h0000_0080);
        bus_rd(8'h14, d, r);
        check(d, 32'h0000_0005);
        $display("test_levels done");
    endtask
    // program: two guarded branches, counted loop, call, wait, redirect
    task automatic test_program;
        logic [7:0] exp[15] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h03, 8'h04,
            8'h03, 8'h04, 8'h05, 8'h09, 8'h06, 8'h07, 8'h0b, 8'h0c, 8'h0e};
        int n;
        bus_wr(8'h00, 32'h0000_0001, r);
        check(r, 32'h0);
        for (n = 0; n < 10 && O_RUNNING !== 1'b1; n++) @(posedge I_CLK);
        for (n = 0; n < 45000 && O_RUNNING !== 1'b0; n++) @(posedge I_CLK);
        check(fa.size(), 32'd15);
        for (n = 0; n < 15 && n < fa.size(); n++) begin
            check(fa[n], exp[n]);
        end
        check(n_ext, 32'd3);
        $display("test_program done");
    endtask
    task automatic test_wait;
        int gap;
        gap = (ft.size() > 11) ? ft[11] - ft[10] : 0;
        // one millisecond is 40000 cycles, plus a few of sequencing
        check(gap >= 40000 && gap <= 40006, 32'h1);
        $display("test_wait done");
    endtask
    task automatic test_redirect;
        check(O_PEND, 32'h0);
        check(n_jclr, 32'd1);
        bus_rd(8'h04, d, r);
        check(d[3:0], 32'h4);
        $display("test_redirect done");
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // whole run is just over 40000 cycles
    initial begin
        repeat (60000) @(posedge I_CLK);
        n_mismatch++;
        summarize();
    end
    initial begin
        {I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} = '0;
        {I_AWADDR, I_ARADDR, I_WDATA, I_PEND_SET} = '0;
        {n_mismatch, n_checks, cyc, n_ext, n_jclr} = '0;
        I_SYS_RST  = 1'b1;
        I_EXT_DONE = 1'b1;
        I_WSTRB    = 4'hf;
        I_GP_IN    = 4'h0;
        I_GP_OUT   = 4'h8;
        repeat (5) @(posedge I_CLK);
        I_SYS_RST <= 1'b0;
        test_refuse();
        test_levels();
        test_program();
        test_wait();
        test_redirect();
        summarize();
    end
endmodule
